//--- verilog/mtr_defs.svh
// Constants for the modem trim and RSSI control register bank.
// Assumes an APB master with 32-bit data and one word per register.
`ifndef MTR_DEFS_SVH
`define MTR_DEFS_SVH
`define MTR_OFS_I_TRIM   12'h000
`define MTR_OFS_Q_TRIM   12'h004
`define MTR_OFS_LO_INV   12'h008
`define MTR_OFS_RSSI     12'h00C
`define MTR_OFS_ADC_TRIM 12'h010
`define MTR_OFS_GPO      12'h014
`define MTR_OFS_SW       12'h018
`define MTR_MASK_TRIM    8'hF8
`define MTR_MASK_LO_INV  8'h0C
`define MTR_MASK_ADC     8'hFA
`define MTR_MASK_GPO     8'h03
`define MTR_MASK_SW      8'hFF
`define MTR_RST_BYTE     8'h00
`define MTR_TRIM_LSB     3
`define MTR_INV_HI       3
`define MTR_INV_LO       2
`define MTR_PWR_BIT      1
`define MTR_SW3_BIT      5
`define MTR_AMP_BIT      3
`endif

//--- verilog/mtr_pkg.sv
// Types shared by the register bank modules.
// Assumes mtr_defs.svh is on the include path.
package mtr_pkg;
  typedef logic [7:0] mtr_byte_t;
endpackage

//--- verilog/mtr_reg_if.sv
// Write strobe and data carried from the bus slave to one register.
// Assumes a single clock shared by both ends.
interface mtr_reg_if;
  logic      we;
  logic [7:0] wdata;
  logic [7:0] q;
  modport ctl (output we, output wdata, input q);
  modport reg_side (input we, input wdata, output q);
endinterface

//--- verilog/mtr_reg8.sv
// One 8-bit masked control register.
// Assumes writes arrive as single-cycle strobes.
`include "mtr_defs.svh"
module mtr_reg8
  import mtr_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  mtr_reg_if.reg_side rif
);
  typedef struct packed {
    mtr_byte_t val;
  } mtr_reg_st_t;
  mtr_reg_st_t s_q;
  mtr_reg_st_t s_d;
  always_comb begin
    s_d = s_q;
    // Unused bits never store, so they read zero
    if (rif.we) begin
      s_d.val = rif.wdata & MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign rif.q = s_q.val;
  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rif.q & ~MASK) == 8'h00)
    else $error("unused bits not zero");
endmodule

//--- verilog/mtr_regs.sv
// Top of the trim, inversion and converter control register bank.
// Assumes an APB master; converter result arrives with a valid strobe.
//
// Local design decisions: the register addresses and the APB register port.
`include "mtr_defs.svh"
module mtr_regs
  import mtr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rssi_sample,
  input  wire logic        rssi_sample_valid,
  output logic      [4:0]  i_offset_code,
  output logic      [4:0]  q_offset_code,
  output logic             lo_invert_bit_hi,
  output logic             lo_invert_bit_lo,
  output logic             lo_invert_mode,
  output logic      [4:0]  rssi_trim_code,
  output logic             rssi_converter_power,
  output logic             general_output_1,
  output logic             general_output_0,
  output logic      [7:0]  analog_switch_bits,
  output logic             switch_three_ctrl,
  output logic             sounder_amp_power
);
  localparam int NREG = 6;
  localparam logic [7:0] MASKS [NREG] = '{
    `MTR_MASK_TRIM, `MTR_MASK_TRIM, `MTR_MASK_LO_INV,
    `MTR_MASK_ADC, `MTR_MASK_GPO, `MTR_MASK_SW};
  localparam logic [11:0] OFS [NREG] = '{
    `MTR_OFS_I_TRIM, `MTR_OFS_Q_TRIM, `MTR_OFS_LO_INV,
    `MTR_OFS_ADC_TRIM, `MTR_OFS_GPO, `MTR_OFS_SW};

  typedef struct packed {
    mtr_byte_t rssi;
    logic [31:0] rdata;
    logic        err;
  } mtr_top_st_t;
  mtr_top_st_t s_q;
  mtr_top_st_t s_d;

  mtr_reg_if rif [NREG] ();
  logic [7:0] rq [NREG];
  logic       access;
  logic       setup;
  logic       hit;
  logic       rssi_hit;
  logic [7:0] rd_byte;

  assign access = psel && penable;
  assign setup  = psel && !penable;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign rif[g].we    = ce && access && pwrite && (paddr == OFS[g]);
      assign rif[g].wdata = pwdata[7:0];
      assign rq[g]        = rif[g].q;
      mtr_reg8 #(.MASK(MASKS[g])) u_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .rif     (rif[g])
      );
    end
  endgenerate

  assign rssi_hit = (paddr == `MTR_OFS_RSSI);

  always_comb begin
    hit     = rssi_hit;
    rd_byte = rssi_hit ? s_q.rssi : `MTR_RST_BYTE;
    for (int k = 0; k < NREG; k++) begin
      if (paddr == OFS[k]) begin
        hit     = 1'b1;
        rd_byte = rq[k];
      end
    end
  end

  always_comb begin
    s_d = s_q;
    // Each conversion strobed while ce is high overwrites the result; read-only to software
    if (rssi_sample_valid) begin
      s_d.rssi = rssi_sample;
    end
    // Read data and error registered at setup, stable through access
    if (setup) begin
      s_d.rdata = {24'h000000, rd_byte};
      s_d.err   = !hit || (pwrite && rssi_hit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // One wait-free access phase; frozen clock enable stalls the bus
  assign pready  = ce;
  assign prdata  = s_q.rdata;
  assign pslverr = access && s_q.err;

  // Offset codes are passed as two's complement, 3 mV per step
  assign i_offset_code = rq[0][7:`MTR_TRIM_LSB];
  assign q_offset_code = rq[1][7:`MTR_TRIM_LSB];
  assign lo_invert_bit_hi = rq[2][`MTR_INV_HI];
  assign lo_invert_bit_lo = rq[2][`MTR_INV_LO];
  // Mixed codes are left to software to avoid; only 11 inverts
  assign lo_invert_mode = lo_invert_bit_hi && lo_invert_bit_lo;
  assign rssi_trim_code = rq[3][7:`MTR_TRIM_LSB];
  assign rssi_converter_power = rq[3][`MTR_PWR_BIT];
  assign general_output_1 = rq[4][1];
  assign general_output_0 = rq[4][0];
  assign analog_switch_bits = rq[5];
  assign switch_three_ctrl = rq[5][`MTR_SW3_BIT];
  assign sounder_amp_power = rq[5][`MTR_AMP_BIT];

  // Code value reflects voltage falling scale; no conversion done here
  logic [7:0] rssi_code_chk;
  assign rssi_code_chk = s_q.rssi;

  a_rssi_capture: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rssi_sample_valid |=> s_q.rssi == $past(rssi_sample))
    else $error("rssi result not captured");
  a_rssi_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !rssi_sample_valid |=> $stable(rssi_code_chk))
    else $error("rssi result changed without sample");
  a_i_trim_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_I_TRIM
    |=> i_offset_code == $past(pwdata[7:3]))
    else $error("i offset write lost");
  a_q_trim_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_Q_TRIM
    |=> q_offset_code == $past(pwdata[7:3]))
    else $error("q offset write lost");
  a_trim_sign: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_I_TRIM
    |=> ($signed(i_offset_code) < 0) == $past(pwdata[7]))
    else $error("offset code sign lost");
  a_inv_mode: assert property (@(posedge pclk) disable iff (!presetn)
    lo_invert_mode == (rq[2] == `MTR_MASK_LO_INV))
    else $error("inversion mode mismatch");
  a_adc_trim_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_ADC_TRIM
    |=> rssi_trim_code == $past(pwdata[7:3])
        && rssi_converter_power == $past(pwdata[1]))
    else $error("converter trim write lost");
  a_power_off: assert property (@(posedge pclk)
    !presetn |-> !rssi_converter_power)
    else $error("converter powered in reset");
  a_gpo_pins: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_GPO
    |=> {general_output_1, general_output_0} == $past(pwdata[1:0]))
    else $error("general outputs not driven");
  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // All software-writable register bits in one word for hold checks
  logic [27:0] ctrl_view;
  assign ctrl_view = {i_offset_code, q_offset_code, rssi_trim_code,
    rssi_converter_power, analog_switch_bits, lo_invert_bit_hi,
    lo_invert_bit_lo, general_output_1, general_output_0};

  // Bus phases as sequences; properties below build on them
  sequence s_access_any;
    ce && access;
  endsequence

  sequence s_bad_setup;
    ce && setup && (!hit || (pwrite && rssi_hit));
  endsequence

  sequence s_good_setup;
    ce && setup && hit && !(pwrite && rssi_hit);
  endsequence

  sequence s_read_setup;
    ce && setup && !pwrite;
  endsequence

  sequence s_stall;
    !ce;
  endsequence

  // Zero wait states; a frozen enable is the only stall
  a_pready_ce: assert property (@(posedge pclk) disable iff (!presetn)
    pready == ce)
    else $error("ready not following enable");

  a_err_access: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> access)
    else $error("error outside access phase");

  a_bad_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_bad_setup ##1 s_access_any |-> pslverr)
    else $error("refused access not flagged");

  a_good_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_good_setup ##1 s_access_any |-> !pslverr)
    else $error("legal access flagged");

  a_read_latch: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup |=> prdata[7:0] == $past(rd_byte))
    else $error("read data not latched at setup");

  a_read_rssi: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && !pwrite && rssi_hit |=> prdata[7:0] == $past(s_q.rssi))
    else $error("result register read wrong");

  // Read data must not move while the master is sampling it
  a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && setup) |=> $stable(prdata))
    else $error("read data moved outside setup");

  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && !hit |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_unmapped_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && !hit |=> $stable(ctrl_view))
    else $error("unmapped write changed state");

  a_rssi_ro: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && rssi_hit && !rssi_sample_valid
    |=> $stable(s_q.rssi))
    else $error("result register written by bus");

  a_stall_regs: assert property (@(posedge pclk) disable iff (!presetn)
    s_stall |=> $stable(ctrl_view))
    else $error("control state moved while frozen");

  a_stall_rssi: assert property (@(posedge pclk) disable iff (!presetn)
    s_stall |=> $stable(s_q.rssi))
    else $error("result moved while frozen");

  a_stall_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    s_stall |=> $stable(prdata))
    else $error("read data moved while frozen");

  a_lo_inv_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_LO_INV
    |=> {lo_invert_bit_hi, lo_invert_bit_lo} == $past(pwdata[3:2]))
    else $error("inversion write lost");

  // Mixed pairs store as written but never select inversion
  a_mixed_normal: assert property (@(posedge pclk) disable iff (!presetn)
    lo_invert_bit_hi != lo_invert_bit_lo |-> !lo_invert_mode)
    else $error("mixed pair selected inversion");

  a_sw_wr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_SW
    |=> analog_switch_bits == $past(pwdata[7:0]))
    else $error("switch write lost");

  a_i_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_I_TRIM)
    |=> $stable(i_offset_code))
    else $error("i offset changed without write");

  a_q_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_Q_TRIM)
    |=> $stable(q_offset_code))
    else $error("q offset changed without write");

  a_q_sign: assert property (@(posedge pclk) disable iff (!presetn)
    ce && access && pwrite && paddr == `MTR_OFS_Q_TRIM
    |=> ($signed(q_offset_code) < 0) == $past(pwdata[7]))
    else $error("q offset sign lost");

  a_lo_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_LO_INV)
    |=> $stable({lo_invert_bit_hi, lo_invert_bit_lo}))
    else $error("inversion changed without write");

  a_adc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_ADC_TRIM)
    |=> $stable(rssi_trim_code))
    else $error("converter trim changed without write");

  a_power_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_ADC_TRIM)
    |=> $stable(rssi_converter_power))
    else $error("converter power changed without write");

  a_gpo_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_GPO)
    |=> $stable({general_output_1, general_output_0}))
    else $error("general outputs changed without write");

  a_sw_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && access && pwrite && paddr == `MTR_OFS_SW)
    |=> $stable(analog_switch_bits))
    else $error("switches changed without write");

  // Reset must clear every control output and the read data even with the enable low
  a_reset_zero: assert property (@(posedge pclk)
    !presetn |-> ctrl_view == 28'h0000000 && prdata == 32'h00000000)
    else $error("state not cleared in reset");
endmodule

//--- bench/mtr_regs_tb.sv
// Self-checking bench for the trim and converter register bank.
// Assumes a zero-wait APB slave and mtr_defs.svh on the include path.
`include "mtr_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module mtr_regs_tb
  import mtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, e, rssi_sample_valid;
  logic [7:0]  rssi_sample, analog_switch_bits;
  logic [4:0]  i_offset_code, q_offset_code, rssi_trim_code;
  logic        lo_invert_bit_hi, lo_invert_bit_lo, lo_invert_mode;
  logic        rssi_converter_power, general_output_1, general_output_0;
  logic        switch_three_ctrl, sounder_amp_power;
  int          bad_count, tests_run;
  logic [11:0] ofs [7] = '{`MTR_OFS_I_TRIM, `MTR_OFS_Q_TRIM, `MTR_OFS_LO_INV,
    `MTR_OFS_RSSI, `MTR_OFS_ADC_TRIM, `MTR_OFS_GPO, `MTR_OFS_SW};
  // Writable bits per register; result register is read-only
  logic [7:0]  ffv [7] = '{8'hF8, 8'hF8, 8'h0C, 8'h00, 8'hFA, 8'h03, 8'hFF};
  logic [7:0]  inv [4] = '{8'h0C, 8'h00, 8'h0C, 8'h00};
  mtr_regs DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rssi_sample(rssi_sample), .rssi_sample_valid(rssi_sample_valid),
    .i_offset_code(i_offset_code), .q_offset_code(q_offset_code),
    .lo_invert_bit_hi(lo_invert_bit_hi), .lo_invert_bit_lo(lo_invert_bit_lo),
    .lo_invert_mode(lo_invert_mode), .rssi_trim_code(rssi_trim_code),
    .rssi_converter_power(rssi_converter_power),
    .general_output_1(general_output_1), .general_output_0(general_output_0),
    .analog_switch_bits(analog_switch_bits),
    .switch_three_ctrl(switch_three_ctrl),
    .sounder_amp_power(sounder_amp_power));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave may stall; the wait ends when pready is high, or else at the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, rssi_sample_valid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rssi_sample = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ofs[i], 32'h0);
      `CHK(r, 32'h0)
    end
    `CHK({i_offset_code, rssi_converter_power, analog_switch_bits}, 14'h0)
    $display("reset values done");
    for (int i = 0; i < 7; i++) if (i != 3) xfer(1'b1, ofs[i], 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ofs[i], 32'h0);
      `CHK(r, {24'h0, ffv[i]})
    end
    `CHK({i_offset_code, q_offset_code}, 10'h3FF)
    `CHK({rssi_trim_code, rssi_converter_power}, 6'h3F)
    `CHK({general_output_1, general_output_0}, 2'h3)
    $display("all ones done");
    xfer(1'b1, `MTR_OFS_I_TRIM, 32'h80);
    xfer(1'b1, `MTR_OFS_Q_TRIM, 32'h78);
    xfer(1'b1, `MTR_OFS_ADC_TRIM, 32'h79);
    xfer(1'b1, `MTR_OFS_GPO, 32'h02);
    settle();
    `CHK({i_offset_code, q_offset_code}, 10'h20F)
    `CHK({rssi_trim_code, rssi_converter_power}, 6'h1E)
    `CHK({general_output_1, general_output_0}, 2'h2)
    xfer(1'b0, `MTR_OFS_ADC_TRIM, 32'h0);
    `CHK(r, 32'h78)
    $display("trim codes done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `MTR_OFS_LO_INV, {24'h0, inv[i]});
      settle();
      `CHK(lo_invert_mode, inv[i] == 8'h0C)
      `CHK({lo_invert_bit_hi, lo_invert_bit_lo}, inv[i][3:2])
    end
    $display("inversion done");
    @(posedge pclk);
    rssi_sample <= 8'hA5;
    rssi_sample_valid <= 1'b1;
    @(posedge pclk);
    rssi_sample <= 8'h5A;
    rssi_sample_valid <= 1'b0;
    xfer(1'b0, `MTR_OFS_RSSI, 32'h0);
    `CHK(r, 32'hA5)
    xfer(1'b1, `MTR_OFS_RSSI, 32'h11);
    `CHK(e, 1'b1)
    xfer(1'b0, `MTR_OFS_RSSI, 32'h0);
    `CHK(r, 32'hA5)
    $display("converter result done");
    xfer(1'b1, 12'h01C, 32'hFF);
    `CHK(e, 1'b1)
    xfer(1'b0, 12'h01C, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    $display("unmapped access done");
    wrap_up();
  end
endmodule
